// [logic/lpcc_regs.svh]
// Summary of operation
// [R1] Four 8-bit software registers: three pair current codes, one on/off.
// [R2] Addresses 0-2 set pair A, B, C current; bits 5:0 code, 7:6 ignored.
// [R3] Address 3 bits 0-5 gate A1,A2,B1,B2,C1,C2; one is on.
// [R4] Every register can be written and read back over the serial line.
// [R5] Enable rising leaves registers cleared so all channels start at zero.
// [R6] Enable held low keeps the device in zero-current shutdown.
// [R7] Shutdown puts all six sink outputs in high impedance.
// [R8] Supply-low lockout forces all six channels off, whatever the registers.
// [R9] Pump starts in 1x and stays there while regulation holds.
// [R10] Regulation shortfall lasting 400 us moves the pump to 1.5x.
// [R11] Mode search restarts at power-up, enable rise, on/off write.
// [R12] Master turns off unconnected channels through the on/off register.
// [R13] Only target address 1100110 is answered.
// [R14] Read: start, address+W, register, restart, address+R, byte, NACK, stop.
// [R15] Code n gives (n+1) half-milliamp steps, 0.5 mA to 32.0 mA.
// [R16] Pump controller takes shortfall input, drives one mode select output.
`ifndef LPCC_REGS_SVH
`define LPCC_REGS_SVH

`define LPCC_TARGET_ADDR 7'h66
`define LPCC_REG_PAIR_A 2'h0
`define LPCC_REG_PAIR_B 2'h1
`define LPCC_REG_PAIR_C 2'h2
`define LPCC_REG_ON_OFF 2'h3
`define LPCC_CODE_W 6
`define LPCC_CODE_RESET 6'h00
`define LPCC_ON_OFF_RESET 6'h00
`define LPCC_BYTE_BITS 4'h8

`define LPCC_CLK_MHZ 25
`define LPCC_SWITCH_DELAY_US 400
`define LPCC_SWITCH_DELAY_CYCLES (`LPCC_SWITCH_DELAY_US * `LPCC_CLK_MHZ)
`define LPCC_DLY_W 16

`define LPCC_IN_W 5
`define LPCC_IN_SCL 0
`define LPCC_IN_SDA 1
`define LPCC_IN_EN 2
`define LPCC_IN_LOCK 3
`define LPCC_IN_SHORT 4
`define LPCC_IN_INIT 5'h03

`endif

// [logic/lpcc_pkg.sv]
package lpcc_pkg;

  typedef enum logic [8:0] {
    SER_IDLE = 9'h001,
    SER_ADDR = 9'h002,
    SER_ADDR_ACK = 9'h004,
    SER_REG = 9'h008,
    SER_REG_ACK = 9'h010,
    SER_WDATA = 9'h020,
    SER_WDATA_ACK = 9'h040,
    SER_RDATA = 9'h080,
    SER_RDATA_ACK = 9'h100
  } lpcc_ser_state_t;

  typedef enum logic [3:0] {
    PUMP_OFF = 4'h1,
    PUMP_WATCH_1X = 4'h2,
    PUMP_WAIT_1X = 4'h4,
    PUMP_1P5X = 4'h8
  } lpcc_pump_state_t;

  typedef struct packed {
    logic hiz;
    logic on;
    logic [5:0] code;
  } lpcc_sink_t;

endpackage : lpcc_pkg

// [logic/lpcc_sync.sv]
`timescale 1ns/1ps
`include "lpcc_regs.svh"

module lpcc_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Raw and filtered levels
  input wire logic [`LPCC_IN_W-1:0] raw_in,
  output logic [`LPCC_IN_W-1:0] clean_out
);

  logic [`LPCC_IN_W-1:0] stage1;
  logic [`LPCC_IN_W-1:0] stage2;
  logic [`LPCC_IN_W-1:0] stage3;
  localparam logic [`LPCC_IN_W-1:0] INIT_LEVELS = `LPCC_IN_INIT;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stage1 <= `LPCC_IN_INIT;
      stage2 <= `LPCC_IN_INIT;
      stage3 <= `LPCC_IN_INIT;
    end else begin
      stage1 <= raw_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change is taken only once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < `LPCC_IN_W; g++) begin : g_filt
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          clean_out[g] <= INIT_LEVELS[g];
        end else if (stage2[g] == stage3[g]) begin
          clean_out[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule : lpcc_sync

// [logic/lpcc_pump_ctrl.sv]
`timescale 1ns/1ps
`include "lpcc_regs.svh"

module lpcc_pump_ctrl #(
  parameter logic [`LPCC_DLY_W-1:0] DELAY_CYCLES =
    `LPCC_DLY_W'(`LPCC_SWITCH_DELAY_CYCLES)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire logic active,
  input wire logic restart,
  input wire logic shortfall,
  // Mode select
  output logic pump_mode_1p5x
);

  lpcc_pkg::lpcc_pump_state_t state;
  logic [`LPCC_DLY_W-1:0] wait_cnt;
  logic expired;

  assign expired = (wait_cnt == DELAY_CYCLES - `LPCC_DLY_W'(1));

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= lpcc_pkg::PUMP_OFF;
    end else begin
      case (state)
        lpcc_pkg::PUMP_OFF: begin
          if (active) begin
            state <= lpcc_pkg::PUMP_WATCH_1X; // see [R9] see [R11]
          end
        end
        lpcc_pkg::PUMP_WATCH_1X: begin
          if (!active) begin
            state <= lpcc_pkg::PUMP_OFF;
          end else if (!restart && shortfall) begin
            state <= lpcc_pkg::PUMP_WAIT_1X; // see [R16]
          end
        end
        lpcc_pkg::PUMP_WAIT_1X: begin
          if (!active) begin
            state <= lpcc_pkg::PUMP_OFF;
          end else if (restart || !shortfall) begin
            state <= lpcc_pkg::PUMP_WATCH_1X; // see [R9]
          end else if (expired) begin
            state <= lpcc_pkg::PUMP_1P5X; // see [R10]
          end
        end
        lpcc_pkg::PUMP_1P5X: begin
          if (!active) begin
            state <= lpcc_pkg::PUMP_OFF;
          end else if (restart) begin
            state <= lpcc_pkg::PUMP_WATCH_1X; // see [R11]
          end
        end
        default: begin
          state <= lpcc_pkg::PUMP_OFF;
        end
      endcase
    end
  end

  // Delay counter runs only while waiting out a shortfall
  always_ff @(posedge sys_clk) begin
    if (!rstn || state != lpcc_pkg::PUMP_WAIT_1X || restart) begin
      wait_cnt <= '0;
    end else if (!expired) begin
      wait_cnt <= wait_cnt + `LPCC_DLY_W'(1); // see [R10]
    end
  end

  assign pump_mode_1p5x = (state == lpcc_pkg::PUMP_1P5X); // see [R16]

endmodule : lpcc_pump_ctrl

// [logic/lpcc_top.sv]
`timescale 1ns/1ps
`include "lpcc_regs.svh"

module lpcc_top #(
  parameter logic [`LPCC_DLY_W-1:0] PUMP_DELAY_CYCLES =
    `LPCC_DLY_W'(`LPCC_SWITCH_DELAY_CYCLES)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Enable and analog status
  input wire logic enable_pin,
  input wire logic supply_low_lockout,
  input wire logic regulation_shortfall,
  // Channel sinks and pump
  output lpcc_pkg::lpcc_sink_t channel_sink_outputs [6],
  output logic pump_mode_1p5x
);

  logic [`LPCC_IN_W-1:0] raw_in;
  logic [`LPCC_IN_W-1:0] clean;
  logic scl;
  logic sda;
  logic enabled;
  logic lockout;
  logic shortfall;

  logic scl_q;
  logic sda_q;
  logic enabled_q;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;

  lpcc_pkg::lpcc_ser_state_t ser_state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] tx_byte;
  logic [7:0] rd_byte;
  logic [1:0] reg_ptr;
  logic read_dir;
  logic master_nack;
  logic sda_drive;
  logic wr_pulse;
  logic onoff_write;
  logic byte_done;

  logic [5:0] pair_a_current_code;
  logic [5:0] pair_b_current_code;
  logic [5:0] pair_c_current_code;
  logic [5:0] channel_on_off;

  function automatic logic [7:0] read_value(input logic [1:0] ptr,
                                            input logic [5:0] a,
                                            input logic [5:0] b,
                                            input logic [5:0] c,
                                            input logic [5:0] en);
    logic [5:0] v;
    if (ptr == `LPCC_REG_PAIR_A) begin
      v = a;
    end else if (ptr == `LPCC_REG_PAIR_B) begin
      v = b;
    end else if (ptr == `LPCC_REG_PAIR_C) begin
      v = c;
    end else begin
      v = en;
    end
    return {2'h0, v};
  endfunction : read_value

  function automatic logic [5:0] pair_code(input logic [1:0] pair,
                                           input logic [5:0] a,
                                           input logic [5:0] b,
                                           input logic [5:0] c);
    logic [5:0] v;
    if (pair == `LPCC_REG_PAIR_A) begin
      v = a;
    end else if (pair == `LPCC_REG_PAIR_B) begin
      v = b;
    end else begin
      v = c;
    end
    return v;
  endfunction : pair_code

  // Pin inputs through the three-stage filter
  assign raw_in[`LPCC_IN_SCL] = scl_in;
  assign raw_in[`LPCC_IN_SDA] = sda_in;
  assign raw_in[`LPCC_IN_EN] = enable_pin;
  assign raw_in[`LPCC_IN_LOCK] = supply_low_lockout;
  assign raw_in[`LPCC_IN_SHORT] = regulation_shortfall;

  lpcc_sync u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .raw_in(raw_in),
    .clean_out(clean)
  );

  assign scl = clean[`LPCC_IN_SCL];
  assign sda = clean[`LPCC_IN_SDA];
  assign enabled = clean[`LPCC_IN_EN];
  assign lockout = clean[`LPCC_IN_LOCK];
  assign shortfall = clean[`LPCC_IN_SHORT];

  // Edge history
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      enabled_q <= 1'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      enabled_q <= enabled;
    end
  end

  assign start_cond = scl && scl_q && sda_q && !sda;
  assign stop_cond = scl && scl_q && !sda_q && sda;
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign byte_done = (bit_cnt == `LPCC_BYTE_BITS);
  assign rd_byte = read_value(reg_ptr, pair_a_current_code,
                              pair_b_current_code, pair_c_current_code,
                              channel_on_off);
  assign wr_pulse = scl_fall && byte_done &&
                    (ser_state == lpcc_pkg::SER_WDATA);
  assign onoff_write = wr_pulse && (reg_ptr == `LPCC_REG_ON_OFF);

  // Bit counter and receive shifter
  always_ff @(posedge sys_clk) begin
    if (!rstn || !enabled || start_cond || stop_cond) begin
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
    end else if (scl_rise && bit_cnt < `LPCC_BYTE_BITS) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift_in <= {shift_in[6:0], sda};
    end else if (scl_rise && byte_done) begin
      // Count the acknowledge bit without shifting it in
      bit_cnt <= bit_cnt + 4'h1;
    end else if (scl_fall && bit_cnt > `LPCC_BYTE_BITS) begin
      bit_cnt <= 4'h0;
    end
  end

  // Serial target engine; SDA is only ever pulled low
  always_ff @(posedge sys_clk) begin
    if (!rstn || !enabled) begin
      ser_state <= lpcc_pkg::SER_IDLE;
      sda_drive <= 1'h0;
      read_dir <= 1'h0;
      master_nack <= 1'h0;
      tx_byte <= 8'h00;
    end else if (stop_cond) begin
      ser_state <= lpcc_pkg::SER_IDLE;
      sda_drive <= 1'h0;
    end else if (start_cond) begin
      ser_state <= lpcc_pkg::SER_ADDR; // see [R14]
      sda_drive <= 1'h0;
    end else begin
      case (ser_state)
        lpcc_pkg::SER_ADDR: begin
          if (scl_fall && byte_done) begin
            if (shift_in[7:1] == `LPCC_TARGET_ADDR) begin // see [R13]
              ser_state <= lpcc_pkg::SER_ADDR_ACK;
              sda_drive <= 1'h1;
              read_dir <= shift_in[0];
            end else begin
              ser_state <= lpcc_pkg::SER_IDLE;
            end
          end
        end
        lpcc_pkg::SER_ADDR_ACK: begin
          if (scl_fall) begin
            if (read_dir) begin
              ser_state <= lpcc_pkg::SER_RDATA; // see [R4]
              tx_byte <= rd_byte;
              sda_drive <= !rd_byte[7];
            end else begin
              ser_state <= lpcc_pkg::SER_REG;
              sda_drive <= 1'h0;
            end
          end
        end
        lpcc_pkg::SER_REG: begin
          if (scl_fall && byte_done) begin
            if (shift_in[7:2] == 6'h00) begin // see [R1]
              ser_state <= lpcc_pkg::SER_REG_ACK;
              sda_drive <= 1'h1;
            end else begin
              ser_state <= lpcc_pkg::SER_IDLE;
            end
          end
        end
        lpcc_pkg::SER_REG_ACK, lpcc_pkg::SER_WDATA_ACK: begin
          if (scl_fall) begin
            ser_state <= lpcc_pkg::SER_WDATA;
            sda_drive <= 1'h0;
          end
        end
        lpcc_pkg::SER_WDATA: begin
          if (scl_fall && byte_done) begin
            ser_state <= lpcc_pkg::SER_WDATA_ACK;
            sda_drive <= 1'h1;
          end
        end
        lpcc_pkg::SER_RDATA: begin
          if (scl_fall) begin
            if (byte_done) begin
              ser_state <= lpcc_pkg::SER_RDATA_ACK;
              sda_drive <= 1'h0;
            end else begin
              tx_byte <= {tx_byte[6:0], 1'h0};
              sda_drive <= !tx_byte[6];
            end
          end
        end
        lpcc_pkg::SER_RDATA_ACK: begin
          if (scl_rise) begin
            master_nack <= sda;
          end else if (scl_fall) begin
            if (master_nack) begin
              ser_state <= lpcc_pkg::SER_IDLE; // see [R14]
            end else begin
              ser_state <= lpcc_pkg::SER_RDATA;
              tx_byte <= rd_byte;
              sda_drive <= !rd_byte[7];
            end
          end
        end
        default: begin
          sda_drive <= 1'h0;
        end
      endcase
    end
  end

  // Register pointer
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_ptr <= `LPCC_REG_PAIR_A;
    end else if (ser_state == lpcc_pkg::SER_REG && scl_fall && byte_done) begin
      reg_ptr <= shift_in[1:0];
    end
  end

  // Register file; cleared throughout shutdown so enable rise starts at zero
  always_ff @(posedge sys_clk) begin
    if (!rstn || !enabled) begin
      pair_a_current_code <= `LPCC_CODE_RESET; // see [R5] see [R6]
      pair_b_current_code <= `LPCC_CODE_RESET;
      pair_c_current_code <= `LPCC_CODE_RESET;
      channel_on_off <= `LPCC_ON_OFF_RESET;
    end else if (wr_pulse) begin
      if (reg_ptr == `LPCC_REG_PAIR_A) begin
        pair_a_current_code <= shift_in[5:0]; // see [R2]
      end else if (reg_ptr == `LPCC_REG_PAIR_B) begin
        pair_b_current_code <= shift_in[5:0];
      end else if (reg_ptr == `LPCC_REG_PAIR_C) begin
        pair_c_current_code <= shift_in[5:0];
      end else begin
        channel_on_off <= shift_in[5:0]; // see [R3] see [R12]
      end
    end
  end

  // Channel sinks
  genvar ch;
  generate
    for (ch = 0; ch < 6; ch++) begin : g_sink
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          channel_sink_outputs[ch] <= '{hiz: 1'h1, on: 1'h0, code: 6'h00};
        end else begin
          channel_sink_outputs[ch].hiz <= !enabled; // see [R7]
          channel_sink_outputs[ch].on <= enabled && !lockout && // see [R8]
                                         channel_on_off[ch]; // see [R3]
          channel_sink_outputs[ch].code <= // see [R15]
            pair_code(2'(ch / 2), pair_a_current_code,
                      pair_b_current_code, pair_c_current_code);
        end
      end
    end
  endgenerate

  lpcc_pump_ctrl #(
    .DELAY_CYCLES(PUMP_DELAY_CYCLES)
  ) u_pump (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .active(enabled),
    .restart(onoff_write || (enabled && !enabled_q)), // see [R11]
    .shortfall(shortfall),
    .pump_mode_1p5x(pump_mode_1p5x)
  );

  assign sda_out = 1'h0;
  assign sda_oe = sda_drive;

endmodule : lpcc_top

// [verification/lpcc_top_properties.sv]
`timescale 1ns/1ps
`include "lpcc_regs.svh"

module lpcc_top_properties #(
  parameter logic [`LPCC_DLY_W-1:0] PUMP_DELAY_CYCLES =
    `LPCC_DLY_W'(`LPCC_SWITCH_DELAY_CYCLES)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Enable and analog status
  input wire logic enable_pin,
  input wire logic supply_low_lockout,
  input wire logic regulation_shortfall,
  // Channel sinks and pump
  input lpcc_pkg::lpcc_sink_t channel_sink_outputs [6],
  input wire logic pump_mode_1p5x
);
  logic any_on;
  logic all_hiz;
  logic any_code;
  logic [15:0] quiet;

  // Summaries over the six sinks
  always_comb begin
    any_on = 1'b0;
    all_hiz = 1'b1;
    any_code = 1'b0;
    for (int i = 0; i < 6; i++) begin
      any_on = any_on | channel_sink_outputs[i].on;
      all_hiz = all_hiz & channel_sink_outputs[i].hiz;
      any_code = any_code | (|channel_sink_outputs[i].code);
    end
  end

  // Cycles of shortfall with the bus and enable quiet
  always_ff @(posedge sys_clk) begin
    if (!rstn || !regulation_shortfall || !enable_pin || !scl_in) begin
      quiet <= 16'h0000;
    end else if (quiet != 16'hffff) begin
      quiet <= quiet + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  shutdown_hiz_a: assert property (
    !enable_pin [*8] |-> all_hiz && !any_on && !any_code)
    else $error("sinks not off in shutdown");
  lockout_off_a: assert property (
    supply_low_lockout [*8] |-> !any_on)
    else $error("channel on under lockout");
  start_zero_a: assert property (
    !enable_pin [*8] ##1 enable_pin [*6] |-> !any_on && !any_code)
    else $error("channels not zero after enable");
  pump_shutdown_a: assert property (
    !enable_pin [*8] |-> !pump_mode_1p5x)
    else $error("pump boost in shutdown");
  pump_switch_a: assert property (
    quiet == PUMP_DELAY_CYCLES + 16'h000c |-> pump_mode_1p5x)
    else $error("pump did not switch in time");
  pair_code_a: assert property (
    channel_sink_outputs[0].code == channel_sink_outputs[1].code &&
    channel_sink_outputs[2].code == channel_sink_outputs[3].code &&
    channel_sink_outputs[4].code == channel_sink_outputs[5].code)
    else $error("pair codes differ");
  ack_timing_a: assert property (
    $changed(sda_oe) |-> !scl_in)
    else $error("data drive changed with clock high");
  bus_silent_a: assert property (
    !enable_pin [*8] |-> !sda_oe)
    else $error("bus driven in shutdown");

  cover property ($rose(pump_mode_1p5x));
  cover property ($rose(sda_oe));
  cover property (supply_low_lockout [*8]);
endmodule : lpcc_top_properties

bind lpcc_top lpcc_top_properties #(
  .PUMP_DELAY_CYCLES(PUMP_DELAY_CYCLES)
) u_props (
  .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
  .supply_low_lockout(supply_low_lockout),
  .regulation_shortfall(regulation_shortfall),
  .channel_sink_outputs(channel_sink_outputs),
  .pump_mode_1p5x(pump_mode_1p5x)
);

// [verification/lpcc_i2c_master.sv]
`timescale 1ns/1ps

module lpcc_i2c_master (
  // Clock
  input wire logic sys_clk,
  // Data line level
  input wire logic sda_line,
  // Driven levels, one is released
  output logic scl,
  output logic sda
);
  localparam int HALF = 10;

  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  // Start when s is one, stop when zero
  task automatic cond(input logic s);
    scl = 1'b0;
    tick(HALF);
    sda = s;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda = ~s;
    tick(HALF);
  endtask : cond

  // Eight bits MSB first, then the ninth bit
  task automatic byte_io(input logic [7:0] tx, input logic nine,
                         output logic [7:0] rx, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      scl = 1'b0;
      tick(3);
      sda = (i > 0) ? tx[i-1] : nine;
      tick(HALF - 3);
      scl = 1'b1;
      tick(HALF / 2);
      if (i > 0) begin
        rx[i-1] = sda_line;
      end else begin
        ack = ~sda_line;
      end
      tick(HALF / 2);
    end
  endtask : byte_io

  task automatic wr(input logic [7:0] r, input logic [7:0] d,
                    output logic [2:0] a);
    logic [7:0] x;
    cond(1'b1);
    byte_io(8'hcc, 1'b1, x, a[2]);
    byte_io(r, 1'b1, x, a[1]);
    byte_io(d, 1'b1, x, a[0]);
    cond(1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic a;
    cond(1'b1);
    byte_io(8'hcc, 1'b1, d, a);
    byte_io(r, 1'b1, d, a);
    cond(1'b1);
    byte_io(8'hcd, 1'b1, d, a);
    byte_io(8'hff, 1'b1, d, a);
    cond(1'b0);
  endtask : rd
endmodule : lpcc_i2c_master

// [verification/led_pair_current_control_regs_tb_top.sv]
`timescale 1ns/1ps
`include "lpcc_regs.svh"

module led_pair_current_control_regs_tb_top;
  localparam logic [`LPCC_DLY_W-1:0] DLY = `LPCC_DLY_W'(200);
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic enable_pin = 1'b0;
  logic supply_low_lockout = 1'b0;
  logic regulation_shortfall = 1'b0;
  logic scl;
  logic m_sda;
  logic sda_out;
  logic sda_oe;
  logic sda_line;
  logic pump_mode_1p5x;
  lpcc_pkg::lpcc_sink_t sinks [6];
  logic [5:0] code_exp [3] = '{6'h00, 6'h00, 6'h00};
  logic [5:0] on_exp = 6'h00;
  logic [23:0] rows [5] = '{24'h00ff3f, 24'h012727, 24'h02c000,
    24'h03ff3f, 24'h031515};
  logic [7:0] rx;
  logic [2:0] acks;
  int failures = 0;
  int tests_run = 0;

  // Open drain data line with pull-up
  assign sda_line = m_sda & (sda_oe ? sda_out : 1'b1);

  lpcc_top #(.PUMP_DELAY_CYCLES(DLY)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
    .supply_low_lockout(supply_low_lockout),
    .regulation_shortfall(regulation_shortfall),
    .channel_sink_outputs(sinks), .pump_mode_1p5x(pump_mode_1p5x));

  lpcc_i2c_master u_master (.sys_clk(sys_clk), .sda_line(sda_line),
    .scl(scl), .sda(m_sda));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check_sinks(input logic hiz, input logic lock);
    lpcc_pkg::lpcc_sink_t e;
    for (int i = 0; i < 6; i++) begin
      e = '{hiz, on_exp[i] & ~lock & ~hiz, code_exp[i/2]};
      tests_run++;
      if (sinks[i] !== e) begin
        failures++;
        $display("[FAIL] %0t sink %0d is %h", $time, i, sinks[i]);
      end
    end
  endtask : check_sinks

  task automatic give_verdict();
    $display("Checks %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    tick(16);
    rstn = 1'h1;
    tick(8);
    check_sinks(1'h1, 1'h0);
    enable_pin = 1'h1;
    tick(10);
    check_sinks(1'h0, 1'h0);
    foreach (rows[k]) begin
      u_master.wr(rows[k][23:16], rows[k][15:8], acks);
      check8({5'h0, acks}, 8'h07);
      u_master.rd(rows[k][23:16], rx);
      check8(rx, rows[k][7:0]);
      if (rows[k][17:16] == 2'h3) begin
        on_exp = rows[k][5:0];
      end else begin
        code_exp[rows[k][17:16]] = rows[k][5:0];
      end
      check_sinks(1'h0, 1'h0);
    end
    // Foreign address and unmapped register
    u_master.cond(1'h1);
    u_master.byte_io(8'hce, 1'h1, rx, acks[0]);
    u_master.cond(1'h0);
    check8({7'h0, acks[0]}, 8'h00);
    u_master.wr(8'h04, 8'h3f, acks);
    check8({5'h0, acks}, 8'h04);
    check_sinks(1'h0, 1'h0);
    // Two data bytes in one write rewrite the same register
    u_master.cond(1'h1);
    u_master.byte_io(8'hcc, 1'h1, rx, acks[2]);
    u_master.byte_io(8'h01, 1'h1, rx, acks[1]);
    u_master.byte_io(8'h11, 1'h1, rx, acks[0]);
    check8({5'h0, acks}, 8'h07);
    u_master.byte_io(8'h22, 1'h1, rx, acks[0]);
    u_master.cond(1'h0);
    code_exp[1] = 6'h22;
    check8({7'h0, acks[0]}, 8'h01);
    supply_low_lockout = 1'h1;
    tick(8);
    check_sinks(1'h0, 1'h1);
    supply_low_lockout = 1'h0;
    tick(8);
    check_sinks(1'h0, 1'h0);
    // Pump mode search
    check8({7'h0, pump_mode_1p5x}, 8'h00);
    regulation_shortfall = 1'h1;
    tick(int'(DLY) - 10);
    check8({7'h0, pump_mode_1p5x}, 8'h00);
    tick(30);
    check8({7'h0, pump_mode_1p5x}, 8'h01);
    u_master.wr(8'h03, 8'h15, acks);
    check8({7'h0, pump_mode_1p5x}, 8'h00);
    tick(int'(DLY));
    check8({7'h0, pump_mode_1p5x}, 8'h01);
    enable_pin = 1'h0;
    tick(8);
    code_exp = '{6'h00, 6'h00, 6'h00};
    on_exp = 6'h00;
    check_sinks(1'h1, 1'h0);
    check8({7'h0, pump_mode_1p5x}, 8'h00);
    regulation_shortfall = 1'h0;
    enable_pin = 1'h1;
    tick(10);
    u_master.rd(8'h03, rx);
    check8(rx, 8'h00);
    // Reset in mid-run clears the registers again
    u_master.wr(8'h00, 8'h2a, acks);
    check8({5'h0, acks}, 8'h07);
    rstn = 1'h0;
    tick(4);
    check_sinks(1'h1, 1'h0);
    rstn = 1'h1;
    tick(10);
    check_sinks(1'h0, 1'h0);
    u_master.rd(8'h00, rx);
    check8(rx, 8'h00);
    give_verdict();
  end
endmodule : led_pair_current_control_regs_tb_top
